/* src/pcmr_top.v */
// Power and clock manager register block with Avalon-MM slave
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcmr_consts.vh"
module pcmr_top #(
    parameter [31:0] PERIPH_IMPL = 32'hFFFF_FFFC
) (
    input wire clk_i,
    input wire resetn_i,
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire slow_clk_i,
    input wire main_clk_i,
    output wire [2:0] programmable_output_bits_o,
    output wire processor_clock_bit_o,
    output wire [31:0] peripheral_gate_bits_o,
    output wire rc_oscillator_on_o,
    output wire main_source_select_o,
    output wire [10:0] pll_feedback_factor_o,
    output wire [7:0] pll_divider_o,
    output wire [1:0] pll_start_kind_o,
    output wire pll_active_o,
    output wire pll_divider_bypass_o,
    output wire [1:0] master_source_field_o,
    output wire [2:0] master_clock_ratio_o,
    output wire master_clock_ready_flag_o,
    output wire pll_locked_o
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Write completes at once; read waits one cycle so data comes from a flop
    reg rd_done_q;
    wire wr_en = avs_write_i & (avs_byteenable_i == 4'hF);
    assign avs_waitrequest_o = avs_read_i & ~rd_done_q;

    // ****************************************************************
    // Input synchronisers, edge detect of sampled slow and main clocks
    // ****************************************************************
    reg [2:0] slow_sync_q;
    reg [2:0] main_sync_q;
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slow_sync_q <= 3'h0;
            main_sync_q <= 3'h0;
        end
        else
        begin
            slow_sync_q <= {slow_sync_q[1:0], slow_clk_i};
            main_sync_q <= {main_sync_q[1:0], main_clk_i};
        end
    end
    wire slow_tick = slow_sync_q[1] & ~slow_sync_q[2];
    wire main_tick = main_sync_q[1] & ~main_sync_q[2];

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [2:0] pout_q;
    reg proc_on_q;
    reg [31:0] per_q;
    reg [31:0] osc_q;
    reg [31:0] pll_q;
    reg [31:0] mck_q;
    wire a_sset = avs_address_i == `PCMR_OFS_SYS_SET;
    wire a_sclr = avs_address_i == `PCMR_OFS_SYS_CLR;
    wire a_pset = avs_address_i == `PCMR_OFS_PER_SET;
    wire a_pclr = avs_address_i == `PCMR_OFS_PER_CLR;
    wire a_osc = avs_address_i == `PCMR_OFS_OSC;
    wire a_pll = avs_address_i == `PCMR_OFS_PLL;
    wire a_mck = avs_address_i == `PCMR_OFS_MCK;
    wire key_ok = avs_writedata_i[`PCMR_KEY_LSB+7:`PCMR_KEY_LSB] == `PCMR_OSC_KEY;
    wire w_osc = wr_en & a_osc & key_ok;
    wire w_pll = wr_en & a_pll;
    wire w_mck = wr_en & a_mck & ((avs_writedata_i & `PCMR_MCK_MASK) != mck_q);
    wire [31:0] per_ok = PERIPH_IMPL & `PCMR_PER_MASK;

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pout_q <= 3'h0;
            proc_on_q <= 1'b1;
            per_q <= 32'h0;
            osc_q <= `PCMR_OSC_RESET;
            pll_q <= `PCMR_PLL_RESET;
            mck_q <= `PCMR_MCK_RESET;
            rd_done_q <= 1'b0;
        end
        else
        begin
            rd_done_q <= avs_read_i & ~rd_done_q;
            if (wr_en & a_sset)
                pout_q <= pout_q | avs_writedata_i[10:8];
            else if (wr_en & a_sclr)
                pout_q <= pout_q & ~avs_writedata_i[10:8];
            if (wr_en & a_sclr & avs_writedata_i[0])
                proc_on_q <= 1'b0;
            else if (avs_read_i | avs_write_i)
                proc_on_q <= 1'b1; // Bus activity models the wake-up
            if (wr_en & a_pset)
                per_q <= per_q | (avs_writedata_i & per_ok);
            else if (wr_en & a_pclr)
                per_q <= per_q & ~(avs_writedata_i & per_ok);
            if (w_osc)
                osc_q <= avs_writedata_i & `PCMR_OSC_MASK;
            if (w_pll)
                pll_q <= avs_writedata_i & `PCMR_PLL_MASK;
            if (wr_en & a_mck)
                mck_q <= avs_writedata_i & `PCMR_MCK_MASK;
        end
    end

    // ****************************************************************
    // Main clock frequency measurement
    // ****************************************************************
    // Counts sampled main edges, so only main below half of clk_i is exact
    reg [4:0] slow_cnt_q;
    reg [15:0] main_cnt_q;
    reg [15:0] freq_q;
    reg freq_ok_q;
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slow_cnt_q <= 5'h0;
            main_cnt_q <= 16'h0;
            freq_q <= 16'h0;
            freq_ok_q <= 1'b0;
        end
        else if (!osc_q[0] || w_osc)
        begin
            slow_cnt_q <= 5'h0;
            main_cnt_q <= 16'h0;
            freq_ok_q <= 1'b0;
        end
        else
        begin
            if (main_tick)
                main_cnt_q <= main_cnt_q + 16'h1;
            if (slow_tick)
            begin
                if (slow_cnt_q == 5'h0)
                begin
                    // First slow edge opens the window; main edges before it do not count
                    main_cnt_q <= 16'h0;
                    slow_cnt_q <= 5'h1;
                end
                else if (slow_cnt_q == `PCMR_MEAS_SLOW)
                begin
                    freq_q <= main_cnt_q + {15'h0, main_tick};
                    freq_ok_q <= 1'b1;
                    slow_cnt_q <= 5'h1;
                    main_cnt_q <= 16'h0;
                end
                else
                    slow_cnt_q <= slow_cnt_q + 5'h1;
            end
        end
    end

    // ****************************************************************
    // PLL lock timer and master clock ready
    // ****************************************************************
    reg [8:0] lock_cnt_q;
    reg lock_q;
    reg [7:0] mck_cnt_q;
    reg mck_rdy_q;
    wire [8:0] lock_target = {pll_q[13:8], 3'h0};
    wire pll_on = pll_q[26:16] != 11'h0;
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lock_cnt_q <= 9'h0;
            lock_q <= 1'b0;
            mck_cnt_q <= 8'h0;
            mck_rdy_q <= 1'b1;
        end
        else
        begin
            if (w_pll)
            begin
                lock_cnt_q <= 9'h0;
                lock_q <= 1'b0;
            end
            else if (!lock_q && slow_tick)
            begin
                if (lock_cnt_q >= lock_target)
                    lock_q <= 1'b1;
                else
                    lock_cnt_q <= lock_cnt_q + 9'h1;
            end
            // PLL as source waits for lock, then a fixed settle in slow ticks
            if (w_mck || (w_pll && mck_q[1:0] == 2'h2))
            begin
                mck_rdy_q <= 1'b0;
                mck_cnt_q <= 8'h0;
            end
            else if (!mck_rdy_q && slow_tick && (mck_q[1:0] != 2'h2 || lock_q))
            begin
                if (mck_cnt_q == `PCMR_MCK_SETTLE)
                    mck_rdy_q <= 1'b1;
                else
                    mck_cnt_q <= mck_cnt_q + 8'h1;
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h0;
        case (avs_address_i)
            `PCMR_OFS_SYS_STATE: rd_d = {21'h0, pout_q, 7'h0, proc_on_q};
            `PCMR_OFS_PER_STATE: rd_d = per_q;
            `PCMR_OFS_OSC: rd_d = osc_q;
            `PCMR_OFS_FREQ: rd_d = {15'h0, freq_ok_q, freq_q};
            `PCMR_OFS_PLL: rd_d = pll_q;
            `PCMR_OFS_MCK: rd_d = mck_q;
            `PCMR_OFS_STATUS: rd_d = {28'h0, mck_rdy_q, 1'b0, lock_q, freq_ok_q};
            default: rd_d = 32'h0;
        endcase
    end
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            avs_readdata_o <= 32'h0;
        else
            avs_readdata_o <= rd_d;
    end

    assign programmable_output_bits_o = pout_q;
    assign processor_clock_bit_o = proc_on_q;
    assign peripheral_gate_bits_o = per_q;
    assign rc_oscillator_on_o = osc_q[0];
    assign main_source_select_o = osc_q[`PCMR_SEL_BIT];
    assign pll_feedback_factor_o = pll_q[26:16];
    assign pll_divider_o = pll_q[7:0];
    assign pll_start_kind_o = pll_q[15:14];
    assign pll_active_o = pll_on & (pll_q[7:0] != 8'h0);
    assign pll_divider_bypass_o = pll_q[7:0] == 8'h1;
    // Reserved source code 11 falls back to slow clock
    assign master_source_field_o = (mck_q[1:0] == 2'h3) ? 2'h0 : mck_q[1:0];
    assign master_clock_ratio_o = (mck_q[4:2] == 3'h7) ? 3'h0 : mck_q[4:2];
    assign master_clock_ready_flag_o = mck_rdy_q;
    assign pll_locked_o = lock_q;
endmodule
`default_nettype wire

/* src/pcmr_consts.vh */
// Constants of the power and clock manager register block
// How it works
// - One written to set register bits 8..10 turns that clock output on.
// - One written to clear register bits 8..10 turns that output off.
// - One written to clear register bit 0 stops the processor clock.
// - State register bit 0 reads one while processor clock runs.
// - State register bits 8..10 show which clock outputs are on.
// - One in peripheral set bit n (2..31) enables peripheral n clock.
// - One in peripheral clear bit n disables peripheral n clock.
// - Peripheral state bit n reads one while peripheral n clock enabled.
// - Gate writes to unimplemented peripheral identifiers change nothing.
// - Oscillator register write needs key 0x37, otherwise whole write dropped.
// - Oscillator bit 0 switches RC oscillator; on after reset.
// - Oscillator bit 24 selects RC (0) or external clock input (1).
// - Frequency low 16 bits hold main cycles counted in 16 slow periods.
// - Frequency bit 16 set only when oscillator on and count valid.
// - PLL divider 0 gives no output, 1 bypasses, others reserved.
// - PLL lock sets after settle count times eight slow cycles.
// - Start kind 0 fast, 2 normal; software uses 2 when PLL off.
// - Feedback factor 0 turns PLL off; otherwise output is input times factor+1.
// - Master source 00 slow, 01 main, 10 PLL; 11 reserved.
// - Master ratio codes 0..6 divide by 1..64; code 7 reserved.
// - Master source or ratio change drops ready until new clock usable.
`ifndef PCMR_CONSTS_VH
`define PCMR_CONSTS_VH
`define PCMR_OFS_SYS_SET 8'h00
`define PCMR_OFS_SYS_CLR 8'h04
`define PCMR_OFS_SYS_STATE 8'h08
`define PCMR_OFS_PER_SET 8'h10
`define PCMR_OFS_PER_CLR 8'h14
`define PCMR_OFS_PER_STATE 8'h18
`define PCMR_OFS_OSC 8'h20
`define PCMR_OFS_FREQ 8'h24
`define PCMR_OFS_PLL 8'h28
`define PCMR_OFS_MCK 8'h30
`define PCMR_OFS_STATUS 8'h68
`define PCMR_OSC_KEY 8'h37
`define PCMR_KEY_LSB 16
`define PCMR_SEL_BIT 24
`define PCMR_OSC_MASK 32'h0100_0001
`define PCMR_PLL_MASK 32'h07FF_FFFF
`define PCMR_PLL_RESET 32'h0000_3F00
`define PCMR_MCK_MASK 32'h0000_001F
`define PCMR_MCK_RESET 32'h0000_0001
`define PCMR_OSC_RESET 32'h0000_0001
`define PCMR_OUT_MASK 3'h7
`define PCMR_PER_MASK 32'hFFFF_FFFC
`define PCMR_MEAS_SLOW 5'h10
`define PCMR_LOCK_MUL 4'h8
`define PCMR_MCK_SETTLE 8'h40
`define PCMR_ST_LOCK 1
`define PCMR_ST_MASTER_CLOCK_READY_FLAG 3
`define PCMR_ST_MAINRDY 0
`endif

/* test/pcmr_chk_sva.sv */
// Port checker for the clock manager register block
`timescale 1ns/1ps
`default_nettype none
`include "pcmr_consts.vh"
module pcmr_chk #(
    parameter [31:0] PERIPH_IMPL = 32'hFFFF_FFFC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [2:0] programmable_output_bits_o,
    input wire logic processor_clock_bit_o,
    input wire logic [31:0] peripheral_gate_bits_o,
    input wire logic rc_oscillator_on_o,
    input wire logic main_source_select_o,
    input wire logic [10:0] pll_feedback_factor_o,
    input wire logic [7:0] pll_divider_o,
    input wire logic pll_active_o,
    input wire logic pll_divider_bypass_o,
    input wire logic [1:0] master_source_field_o,
    input wire logic [2:0] master_clock_ratio_o,
    input wire logic master_clock_ready_flag_o,
    input wire logic pll_locked_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Partial writes are ignored, so only full words count as writes
    wire wa = avs_write_i && (avs_byteenable_i == 4'hF);
    wire [31:0] wd = avs_writedata_i;
    wire [7:0] ad = avs_address_i;
    // ****************************************
    // Assertions
    // ****************************************
    a_out_set_bits: assert property (wa && ad == `PCMR_OFS_SYS_SET |=>
        programmable_output_bits_o == $past(programmable_output_bits_o | wd[10:8]))
        else $error("clock output set wrong");
    a_out_clr_bits: assert property (wa && ad == `PCMR_OFS_SYS_CLR |=>
        programmable_output_bits_o == $past(programmable_output_bits_o & ~wd[10:8]))
        else $error("clock output clear wrong");
    a_proc_clock_stop: assert property (wa && ad == `PCMR_OFS_SYS_CLR && wd[0] |=>
        !processor_clock_bit_o) else $error("processor clock not stopped");
    a_periph_gate_set: assert property (wa && ad == `PCMR_OFS_PER_SET |=>
        peripheral_gate_bits_o == $past(peripheral_gate_bits_o |
        (wd & PERIPH_IMPL & `PCMR_PER_MASK)))
        else $error("peripheral set wrong");
    a_periph_gate_clr: assert property (wa && ad == `PCMR_OFS_PER_CLR |=>
        peripheral_gate_bits_o == $past(peripheral_gate_bits_o &
        ~(wd & PERIPH_IMPL & `PCMR_PER_MASK)))
        else $error("peripheral clear wrong");
    a_osc_key_guard: assert property (wa && ad == `PCMR_OFS_OSC && wd[23:16] != 8'h37 |=>
        $stable(rc_oscillator_on_o) && $stable(main_source_select_o))
        else $error("oscillator changed without key");
    a_osc_field_load: assert property (wa && ad == `PCMR_OFS_OSC && wd[23:16] == 8'h37 |=>
        rc_oscillator_on_o == $past(wd[0]) && main_source_select_o == $past(wd[24]))
        else $error("oscillator fields wrong");
    a_pll_active_map: assert property (pll_active_o ==
        (pll_feedback_factor_o != 11'h000 && pll_divider_o != 8'h00))
        else $error("pll active wrong");
    a_pll_bypass_map: assert property (pll_divider_bypass_o == (pll_divider_o == 8'h01))
        else $error("divider bypass wrong");
    a_pll_lock_drop: assert property (wa && ad == `PCMR_OFS_PLL |-> ##[1:2] !pll_locked_o)
        else $error("lock kept after pll write");
    a_mck_ready_drop: assert property (wa && ad == `PCMR_OFS_MCK && wd[1:0] != 2'h3 &&
        wd[4:2] != 3'h7 && wd[4:0] != {master_clock_ratio_o, master_source_field_o}
        |-> ##[1:2] !master_clock_ready_flag_o) else $error("ready kept after change");
    a_mck_code_legal: assert property (master_source_field_o != 2'h3 &&
        master_clock_ratio_o != 3'h7) else $error("reserved master code shown");
    c_proc_stop: cover property ($fell(processor_clock_bit_o));
    c_lock_rise: cover property ($rose(pll_locked_o));
    c_ready_rise: cover property ($rose(master_clock_ready_flag_o));
endmodule
bind pcmr_top pcmr_chk #(.PERIPH_IMPL(PERIPH_IMPL)) u_pcmr_chk (.clk_i, .resetn_i,
    .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .programmable_output_bits_o, .processor_clock_bit_o, .peripheral_gate_bits_o,
    .rc_oscillator_on_o, .main_source_select_o, .pll_feedback_factor_o, .pll_divider_o,
    .pll_active_o, .pll_divider_bypass_o, .master_source_field_o, .master_clock_ratio_o,
    .master_clock_ready_flag_o, .pll_locked_o);
`default_nettype wire

/* test/test_pcmr_top.sv */
// Self-checking bench for the clock manager register block
`timescale 1ns/1ps
`default_nettype none
`include "pcmr_consts.vh"
module test_pcmr_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic slow = 1'b0;
    logic mainc = 1'b0;
    logic [2:0] div8 = 3'h0;
    logic [31:0] q;
    wire [31:0] rdata;
    wire wait_o, pcb, rc_on, sel, act, byp, rdy, lck;
    wire [2:0] pob, ratio;
    wire [1:0] src;
    wire [10:0] fac;
    wire [31:0] per;
    wire [7:0] pdiv;
    wire [1:0] skind;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    pcmr_top u_pcmr_top (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .slow_clk_i(slow),
        .main_clk_i(mainc), .programmable_output_bits_o(pob), .processor_clock_bit_o(pcb),
        .peripheral_gate_bits_o(per), .rc_oscillator_on_o(rc_on), .main_source_select_o(sel),
        .pll_feedback_factor_o(fac), .pll_divider_o(pdiv), .pll_start_kind_o(skind),
        .pll_active_o(act),
        .pll_divider_bypass_o(byp), .master_source_field_o(src), .master_clock_ratio_o(ratio),
        .master_clock_ready_flag_o(rdy), .pll_locked_o(lck));
    always #25 clk_i = ~clk_i;
    // Slow clock is 8 system cycles, main clock 4, so 16 slow periods hold 32 main edges
    always @(posedge clk_i)
    begin
        div8 <= div8 + 3'h1;
        mainc <= div8[1];
        slow <= div8[2];
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            results();
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One access; an idle edge before each keeps strobes from being driven twice at once
    // Request holds until the edge that sees waitrequest low; only the bench timeout ends it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do
            @(posedge clk_i);
        while (wait_o !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q, e);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdc("sys_state", `PCMR_OFS_SYS_STATE, 32'h0000_0001);
        rdc("per_state", `PCMR_OFS_PER_STATE, 32'h0000_0000);
        rdc("osc", `PCMR_OFS_OSC, 32'h0000_0001);
        rdc("pll", `PCMR_OFS_PLL, 32'h0000_3F00);
        rdc("mck", `PCMR_OFS_MCK, 32'h0000_0001);
        rdc("unmapped", 8'h0C, 32'h0000_0000);
        $display("test reset done");
        bus(1'b1, `PCMR_OFS_SYS_SET, 32'h0000_0500);
        rdc("sys_on", `PCMR_OFS_SYS_STATE, 32'h0000_0501);
        bus(1'b1, `PCMR_OFS_SYS_SET, 32'h0000_0200);
        rdc("sys_add", `PCMR_OFS_SYS_STATE, 32'h0000_0701);
        bus(1'b1, `PCMR_OFS_SYS_CLR, 32'h0000_0401);
        @(negedge clk_i);
        chk("proc_clock", {31'h0, pcb}, 32'h0000_0000);
        chk("out_port", {29'h0, pob}, 32'h0000_0003);
        bus(1'b0, `PCMR_OFS_SYS_STATE, 32'h0000_0000);
        chk("sys_off", q & 32'h0000_0700, 32'h0000_0300);
        rdc("set_read", `PCMR_OFS_SYS_SET, 32'h0000_0000);
        rdc("clr_read", `PCMR_OFS_SYS_CLR, 32'h0000_0000);
        $display("test system clocks done");
        bus(1'b1, `PCMR_OFS_PER_SET, 32'hFFFF_FFFF);
        rdc("per_set", `PCMR_OFS_PER_STATE, 32'hFFFF_FFFC);
        bus(1'b1, `PCMR_OFS_PER_CLR, 32'h0000_FF03);
        rdc("per_clr", `PCMR_OFS_PER_STATE, 32'hFFFF_00FC);
        chk("per_port", per, 32'hFFFF_00FC);
        rdc("per_read", `PCMR_OFS_PER_CLR, 32'h0000_0000);
        $display("test peripheral clocks done");
        bus(1'b1, `PCMR_OFS_OSC, 32'h01AA_0000);
        rdc("osc_nokey", `PCMR_OFS_OSC, 32'h0000_0001);
        bus(1'b1, `PCMR_OFS_OSC, 32'h0137_0000);
        rdc("osc_key", `PCMR_OFS_OSC, 32'h0100_0000);
        chk("osc_port", {30'h0, sel, rc_on}, 32'h0000_0002);
        repeat (200) @(posedge clk_i);
        bus(1'b0, `PCMR_OFS_FREQ, 32'h0000_0000);
        chk("freq_off", {31'h0, q[16]}, 32'h0000_0000);
        bus(1'b1, `PCMR_OFS_OSC, 32'h0037_0001);
        repeat (60) if (q[16] !== 1'b1) bus(1'b0, `PCMR_OFS_FREQ, 32'h0000_0000);
        chk("freq", q, 32'h0001_0020);
        $display("test oscillator done");
        bus(1'b1, `PCMR_OFS_PLL, 32'h0005_8201);
        n = 0;
        while (lck !== 1'b1 && n < 400) begin @(negedge clk_i); n++; end
        chk("lock_time", {31'h0, n >= 120 && n <= 200}, 32'h0000_0001);
        rdc("pll", `PCMR_OFS_PLL, 32'h0005_8201);
        chk("pll_port", {19'h0, act, byp, fac}, 32'h0000_1805);
        chk("pll_kind", {22'h0, skind, pdiv}, 32'h0000_0201);
        bus(1'b1, `PCMR_OFS_PLL, 32'h0000_8001);
        @(negedge clk_i);
        chk("pll_off", {31'h0, act}, 32'h0000_0000);
        $display("test pll done");
        bus(1'b1, `PCMR_OFS_MCK, 32'h0000_0019);
        @(negedge clk_i);
        chk("mck_drop", {31'h0, rdy}, 32'h0000_0000);
        n = 0;
        while (rdy !== 1'b1 && n < 1000) begin @(negedge clk_i); n++; end
        chk("mck_ready", {31'h0, rdy}, 32'h0000_0001);
        chk("mck_port", {27'h0, ratio, src}, 32'h0000_0019);
        bus(1'b1, `PCMR_OFS_MCK, 32'hFFFF_FFFF);
        rdc("mck_rsvd", `PCMR_OFS_MCK, 32'h0000_001F);
        chk("mck_code", {27'h0, ratio, src}, 32'h0000_0000);
        $display("test master clock done");
        results();
    end
endmodule
`default_nettype wire
